// ### rtl/low_region_limit_chip_select.sv
// low-region and mid-range memory chip-select decode with ready control
//
// What this block does
// [RULE1] low region always starts at address zero
// [RULE2] software loads only listed low-limit patterns
// [RULE3] low select when address top <= limit|3F
// [RULE4] low select idle until limit register accessed
// [RULE5] low limit ready bits steer low accesses
// [RULE6] four mid selects in one relocatable block
// [RULE7] one-hot seven-bit size field, 8K to 512K
// [RULE8] software sets exactly one size bit
// [RULE9] four equal quarters, select 0 lowest
// [RULE10] base bits 15..9 give address bits 19..13
// [RULE11] software aligns base to block size
// [RULE12] mid selects idle until base and size accessed
// [RULE13] mid base ready bits steer mid accesses
// [RULE14] 512K mid needs base zero, no low limit
// [RULE15] registers at A2H, A6H and A8H
// [RULE16] ready bit 2 ignores external ready, 1..0 waits
// [RULE17] internal waits overlap external ready
// [RULE18] all selects high during reset
// [RULE19] any read or write counts as access
`timescale 1ns/1ps
`include "low_region_limit_consts.svh"
module low_region_limit_chip_select (
  input wire logic clk_i, // processor clock, 10 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire low_region_limit_pkg::low_region_limit_cycle_t cycle_i, // cpu or dma memory cycle
  input wire low_region_limit_pkg::low_region_limit_reg_req_t reg_i, // control-block access
  input wire logic ext_rdy_i, // external ready, high = ready
  output logic [15:0] rdata_o, // control-block read data
  output logic low_region_select_n_o, // low select, active low
  output logic [3:0] mid_region_select_n_o, // mid selects, active low
  output logic ready_o // internal ready for the current access
);
  import low_region_limit_pkg::*;

  logic [15:0] low_limit_r, low_limit_nxt;
  logic [15:0] mid_base_r, mid_base_nxt;
  logic [15:0] mid_size_r, mid_size_nxt;
  logic low_seen_r, low_seen_nxt;
  logic base_seen_r, base_seen_nxt;
  logic size_seen_r, size_seen_nxt;
  logic [15:0] rdata_nxt;
  logic hit_low, hit_low_raw;
  logic [3:0] hit_mid;
  logic low_sel_n_r, low_sel_n_nxt;
  logic [3:0] mid_sel_n_r, mid_sel_n_nxt;
  logic cyc_prev_r;
  logic start;
  logic [2:0] mode;
  low_region_limit_region_t region;
  logic acc;

  // register file
  always_comb begin
    low_limit_nxt = low_limit_r;
    mid_base_nxt = mid_base_r;
    mid_size_nxt = mid_size_r;
    low_seen_nxt = low_seen_r;
    base_seen_nxt = base_seen_r;
    size_seen_nxt = size_seen_r;
    rdata_nxt = rdata_o;
    acc = reg_i.rd || reg_i.wr;
    unique case (reg_i.ofs)
      `LOW_REGION_LIMIT_OFS_LOW_LIMIT: begin // see [RULE15]
        if (acc) low_seen_nxt = 1'b1; // see [RULE4] [RULE19]
        if (reg_i.wr) low_limit_nxt = reg_i.wdata;
        if (reg_i.rd) rdata_nxt = low_limit_r;
      end
      `LOW_REGION_LIMIT_OFS_MID_BASE: begin // see [RULE15]
        if (acc) base_seen_nxt = 1'b1; // see [RULE12] [RULE19]
        if (reg_i.wr) mid_base_nxt = reg_i.wdata;
        if (reg_i.rd) rdata_nxt = mid_base_r;
      end
      `LOW_REGION_LIMIT_OFS_MID_SIZE: begin // see [RULE15]
        if (acc) size_seen_nxt = 1'b1; // see [RULE12] [RULE19]
        if (reg_i.wr) mid_size_nxt = reg_i.wdata;
        if (reg_i.rd) rdata_nxt = mid_size_r;
      end
      default: begin
        if (reg_i.rd) rdata_nxt = 16'h0000;
      end
    endcase
  end

  // low region: bottom fixed at zero, top = limit with low bits forced to ones
  assign hit_low_raw = cycle_i.addr[19:4] <= (low_limit_r | 16'h003F); // see [RULE1] [RULE3]
  assign hit_low = cycle_i.valid && low_seen_r && hit_low_raw; // see [RULE4]

  low_region_limit_mid_decode u_mid (
    .addr_i(cycle_i.addr),
    .size_i(mid_size_r[`LOW_REGION_LIMIT_SIZE_LSB +: `LOW_REGION_LIMIT_SIZE_W]),
    .base_i(mid_base_r[`LOW_REGION_LIMIT_MID_BASE_LSB +: 7]),
    .enable_i(cycle_i.valid && base_seen_r && size_seen_r), // see [RULE12]
    .hit_o(hit_mid)
  );

  // low wins on overlap; software keeps them apart for the 512K case
  always_comb begin
    low_sel_n_nxt = ~hit_low;
    mid_sel_n_nxt = hit_low ? 4'hF : ~hit_mid; // see [RULE6]
    region = LOW_REGION_LIMIT_SEL_NONE;
    mode = 3'h0;
    if (hit_low) begin
      region = LOW_REGION_LIMIT_SEL_LOW;
      mode = low_limit_r[2:0]; // see [RULE5]
    end else if (hit_mid != 4'h0) begin
      region = LOW_REGION_LIMIT_SEL_MID;
      mode = mid_base_r[2:0]; // see [RULE13]
    end
  end

  // ready timing starts once per selected cycle
  assign start = cycle_i.valid && !cyc_prev_r && (region != LOW_REGION_LIMIT_SEL_NONE);

  low_region_limit_ready_gen u_rdy (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start),
    .mode_i(mode),
    .ext_rdy_i(ext_rdy_i),
    .ready_o(ready_o)
  );

  // undefined-at-reset registers get zero only for a clean simulation start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_limit_r <= 16'h0000;
      mid_base_r <= 16'h0000;
      mid_size_r <= 16'h0000;
      low_seen_r <= 1'b0;
      base_seen_r <= 1'b0;
      size_seen_r <= 1'b0;
      rdata_o <= 16'h0000;
      low_sel_n_r <= 1'b1; // see [RULE18]
      mid_sel_n_r <= 4'hF; // see [RULE18]
      cyc_prev_r <= 1'b0;
    end else begin
      low_limit_r <= low_limit_nxt;
      mid_base_r <= mid_base_nxt;
      mid_size_r <= mid_size_nxt;
      low_seen_r <= low_seen_nxt;
      base_seen_r <= base_seen_nxt;
      size_seen_r <= size_seen_nxt;
      rdata_o <= rdata_nxt;
      low_sel_n_r <= low_sel_n_nxt;
      mid_sel_n_r <= mid_sel_n_nxt;
      cyc_prev_r <= cycle_i.valid;
    end
  end

  assign low_region_select_n_o = low_sel_n_r;
  assign mid_region_select_n_o = mid_sel_n_r;

  a_low_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !low_seen_r |=> low_region_select_n_o) // see [RULE4]
    else $error("low select active before limit accessed");
  a_mid_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(base_seen_r && size_seen_r) |=> mid_region_select_n_o == 4'hF) // see [RULE12]
    else $error("mid select active before base and size accessed");
  a_low_compare: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cycle_i.valid && low_seen_r && cycle_i.addr[19:4] <= (low_limit_r | 16'h003F)
    |=> !low_region_select_n_o) // see [RULE3]
    else $error("low select missing for address under limit");
  a_mid_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $onehot0(~mid_region_select_n_o)) // see [RULE9]
    else $error("more than one mid select active");
  a_mid_quarter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cycle_i.valid && base_seen_r && size_seen_r && !hit_low && mid_size_r[14:8] == 7'h04
    && cycle_i.addr[19:15] == mid_base_r[15:11]
    |=> !mid_region_select_n_o[$past(cycle_i.addr[14:13])]) // see [RULE9] [RULE10]
    else $error("wrong quarter select for 32K block");
  a_access_rd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_i.rd && reg_i.ofs == 8'hA2 |=> low_seen_r) // see [RULE19]
    else $error("read did not enable low select");
  a_write_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_i.wr && reg_i.ofs == 8'hA6 ##1 reg_i.rd && reg_i.ofs == 8'hA6 && !reg_i.wr
    |=> rdata_o == $past(mid_base_r)) // see [RULE15]
    else $error("mid base readback wrong");
  c_low_hit: cover property (@(posedge clk_i) disable iff (!rst_n_i) !low_region_select_n_o);
  c_mid_last: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !mid_region_select_n_o[3]);
  c_mid_ready: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    region == LOW_REGION_LIMIT_SEL_MID && start ##[1:6] ready_o);
endmodule

// ### rtl/low_region_limit_consts.svh
// offsets, field positions and widths for the low/mid chip-select block
`ifndef LOW_REGION_LIMIT_CONSTS_SVH
`define LOW_REGION_LIMIT_CONSTS_SVH
`define LOW_REGION_LIMIT_OFS_LOW_LIMIT 8'hA2
`define LOW_REGION_LIMIT_OFS_MID_BASE 8'hA6
`define LOW_REGION_LIMIT_OFS_MID_SIZE 8'hA8
`define LOW_REGION_LIMIT_LOW_LSB 6
`define LOW_REGION_LIMIT_MID_BASE_LSB 9
`define LOW_REGION_LIMIT_SIZE_LSB 8
`define LOW_REGION_LIMIT_SIZE_W 7
`define LOW_REGION_LIMIT_RDY_IGN_BIT 2
`define LOW_REGION_LIMIT_ADDR_W 20
`define LOW_REGION_LIMIT_REG_W 16
`define LOW_REGION_LIMIT_WAIT_W 2
`endif

// ### rtl/low_region_limit_mid_decode.sv
// mid-range block decode into four quarter selects
`timescale 1ns/1ps
`include "low_region_limit_consts.svh"
module low_region_limit_mid_decode (
  input wire logic [19:0] addr_i, // internal address
  input wire logic [6:0] size_i, // one-hot block size, 8K..512K
  input wire logic [6:0] base_i, // base bits 19..13
  input wire logic enable_i, // both registers accessed
  output logic [3:0] hit_o // active-high quarter hits
);
  import low_region_limit_pkg::*;
  logic [19:0] base_addr;
  logic [19:0] mask;
  logic [19:0] blk_bytes;
  logic [1:0] quarter;
  always_comb begin
    base_addr = {base_i, 13'h0000}; // see [RULE10]
    blk_bytes = 20'h00000;
    quarter = 2'h0;
    // one-hot size: bit k gives 8K << k; several bits just OR the sizes
    for (int k = 0; k < `LOW_REGION_LIMIT_SIZE_W; k++) begin
      if (size_i[k]) begin
        blk_bytes = blk_bytes | (20'h02000 << k); // see [RULE7]
        // quarter index sits in the two bits just under the block size
        quarter = quarter | addr_i[12 + k -: 2]; // see [RULE9]
      end
    end
    mask = ~(blk_bytes - 20'h00001);
    hit_o = 4'h0;
    if (enable_i && (blk_bytes != 20'h00000) && ((addr_i & mask) == (base_addr & mask))) begin
      hit_o[quarter] = 1'b1; // see [RULE6] [RULE9]
    end
  end
endmodule

// ### rtl/low_region_limit_pkg.sv
// types for the low/mid chip-select block
package low_region_limit_pkg;
  // a bus cycle as seen by the chip-select logic
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
  } low_region_limit_cycle_t;
  // access to the internal control block
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] ofs;
    logic [15:0] wdata;
  } low_region_limit_reg_req_t;
  typedef enum logic [1:0] {
    LOW_REGION_LIMIT_SEL_NONE,
    LOW_REGION_LIMIT_SEL_LOW,
    LOW_REGION_LIMIT_SEL_MID
  } low_region_limit_region_t;
  typedef enum logic {
    LOW_REGION_LIMIT_IDLE,
    LOW_REGION_LIMIT_WAIT
  } low_region_limit_rdy_state_t;
endpackage

// ### rtl/low_region_limit_ready_gen.sv
// wait-state generator combining internal waits with external ready
`timescale 1ns/1ps
`include "low_region_limit_consts.svh"
module low_region_limit_ready_gen (
  input wire logic clk_i, // processor clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic start_i, // first cycle of a selected access
  input wire logic [2:0] mode_i, // ready_mode_bits of the region
  input wire logic ext_rdy_i, // external ready, high = ready
  output logic ready_o // access may complete
);
  import low_region_limit_pkg::*;
  low_region_limit_rdy_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic int_done;
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    mode_nxt = mode_r;
    ready_o = 1'b0;
    int_done = 1'b0;
    unique case (state_r)
      LOW_REGION_LIMIT_IDLE: begin
        if (start_i) begin
          mode_nxt = mode_i;
          cnt_nxt = mode_i[1:0]; // see [RULE16]
          state_nxt = LOW_REGION_LIMIT_WAIT;
        end
      end
      LOW_REGION_LIMIT_WAIT: begin
        int_done = (cnt_r == 2'h0);
        // internal count and external ready overlap, longer one wins
        ready_o = int_done && (mode_r[`LOW_REGION_LIMIT_RDY_IGN_BIT] || ext_rdy_i); // see [RULE16] [RULE17]
        if (!int_done) begin
          cnt_nxt = cnt_r - 2'h1;
        end
        if (ready_o) begin
          state_nxt = LOW_REGION_LIMIT_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= LOW_REGION_LIMIT_IDLE;
      cnt_r <= 2'h0;
      mode_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mode_r <= mode_nxt;
    end
  end

  a_wait_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_i && state_r == LOW_REGION_LIMIT_IDLE && mode_i == 3'h7 |-> !ready_o [*4] ##1 ready_o) // see [RULE16]
    else $error("three ignore-ready waits not honoured");
  a_zero_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_i && state_r == LOW_REGION_LIMIT_IDLE && mode_i == 3'h4 |=> ready_o) // see [RULE16]
    else $error("zero-wait access not ready next cycle");
  a_ext_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == LOW_REGION_LIMIT_WAIT && !mode_r[2] && !ext_rdy_i |-> !ready_o) // see [RULE17]
    else $error("ready given while external ready low");
  a_parallel_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_i && state_r == LOW_REGION_LIMIT_IDLE && mode_i == 3'h2 ##1 ext_rdy_i [*2] ##1 ext_rdy_i
    |-> ready_o) // see [RULE17]
    else $error("waits not overlapped with external ready");
  c_ready_ext: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == LOW_REGION_LIMIT_WAIT && !mode_r[2] && cnt_r == 2'h0 && !ext_rdy_i);
endmodule

// ### tb/low_region_limit_mem_model.sv
// external memory model answering selected accesses, promptly or slowly
`timescale 1ns/1ps
module low_region_limit_mem_model (
  input wire logic clk_i, // processor clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [4:0] sel_n_i, // all memory selects, active low
  input wire logic [3:0] delay_i, // not-ready cycles per access
  output logic ext_rdy_o // external ready, high = ready
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic hit;
  assign hit = ~&sel_n_i;
  always_comb begin
    cnt_nxt = hit ? ((cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1) : 4'h0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // line is pulled up, so an unselected device reads as ready
  assign ext_rdy_o = !(hit && cnt_r < delay_i);
endmodule

// ### tb/test_low_region_limit_chip_select.sv
// self-checking bench for the low/mid chip-select block
`timescale 1ns/1ps
`include "low_region_limit_consts.svh"
module test_low_region_limit_chip_select;
  import low_region_limit_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  low_region_limit_cycle_t cyc = '0;
  low_region_limit_reg_req_t req = '0;
  logic ext_rdy, low_n, ready;
  logic [15:0] rdata;
  logic [3:0] mid_n;
  logic [3:0] dly = 4'h0;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'd98740;
  logic [15:0] lim, base, size;
  logic lim_acc, base_acc, size_acc;
  low_region_limit_chip_select low_region_limit_chip_select_i (.clk_i(clk), .rst_n_i(rst_n), .cycle_i(cyc),
    .reg_i(req), .ext_rdy_i(ext_rdy), .rdata_o(rdata), .low_region_select_n_o(low_n),
    .mid_region_select_n_o(mid_n), .ready_o(ready));
  low_region_limit_mem_model low_region_limit_mem_model_i (.clk_i(clk), .rst_n_i(rst_n), .sel_n_i({low_n, mid_n}),
    .delay_i(dly), .ext_rdy_o(ext_rdy));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_low(logic [19:0] a);
    return lim_acc && (a[19:4] <= (lim | 16'h003F));
  endfunction
  function automatic logic [3:0] exp_mid(logic [19:0] a);
    logic [19:0] blk, b, off;
    blk = '0;
    for (int k = 0; k < 7; k++) if (size[8 + k]) blk = 20'h02000 << k;
    b = {base[15:9], 13'h0000};
    off = a - b;
    if (!(base_acc && size_acc) || exp_low(a) || a < b || off >= blk) return 4'h0;
    return 4'h1 << (off / (blk >> 2));
  endfunction
  task automatic chk(logic [19:0] seen, logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_op(logic w, logic [7:0] ofs, logic [15:0] d);
    logic [15:0] e;
    e = (ofs == `LOW_REGION_LIMIT_OFS_LOW_LIMIT) ? lim : (ofs == `LOW_REGION_LIMIT_OFS_MID_BASE) ? base :
        (ofs == `LOW_REGION_LIMIT_OFS_MID_SIZE) ? size : 16'h0000;
    @(posedge clk) #1;
    req = '{rd: !w, wr: w, ofs: ofs, wdata: d};
    @(posedge clk) #1;
    req = '0;
    if (!w) chk(rdata, e);
    if (ofs == `LOW_REGION_LIMIT_OFS_LOW_LIMIT) lim_acc = 1'b1;
    if (ofs == `LOW_REGION_LIMIT_OFS_MID_BASE) base_acc = 1'b1;
    if (ofs == `LOW_REGION_LIMIT_OFS_MID_SIZE) size_acc = 1'b1;
    if (w && ofs == `LOW_REGION_LIMIT_OFS_LOW_LIMIT) lim = d;
    if (w && ofs == `LOW_REGION_LIMIT_OFS_MID_BASE) base = d;
    if (w && ofs == `LOW_REGION_LIMIT_OFS_MID_SIZE) size = d;
  endtask
  task automatic mem(logic [19:0] a);
    logic l;
    logic [3:0] m;
    logic [2:0] md;
    int lat;
    l = exp_low(a);
    m = exp_mid(a);
    md = l ? lim[2:0] : base[2:0];
    lat = int'(md[1:0]) + 1;
    if (!md[2] && int'(dly) + 1 > lat) lat = int'(dly) + 1;
    @(posedge clk) #1;
    cyc = '{valid: 1'b1, addr: a};
    for (int k = 0; k <= lat + 1; k++) begin
      @(negedge clk);
      if (k == 1) chk({low_n, mid_n}, {!l, ~m});
      if (l || m != 4'h0) chk(ready, k == lat);
    end
    @(posedge clk) #1;
    cyc = '0;
    repeat (2) @(posedge clk);
    dly = 4'(rnd() % 5);
  endtask
  task automatic mid_run(int k, logic [6:0] b7, logic [2:0] md);
    logic [19:0] b, qs;
    reg_op(1'b1, `LOW_REGION_LIMIT_OFS_MID_SIZE, 16'h0100 << k);
    reg_op(1'b1, `LOW_REGION_LIMIT_OFS_MID_BASE, {b7, 6'h00, md});
    reg_op(1'b0, `LOW_REGION_LIMIT_OFS_MID_BASE, 16'h0000);
    b = {b7, 13'h0000};
    qs = 20'h00800 << k;
    for (int q = 0; q < 4; q++) mem(b + 20'(q) * qs + rnd() % qs);
    mem(b - 20'h00001);
    mem(b + (qs << 2));
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    {lim_acc, base_acc, size_acc, lim, base, size} = '0;
    cyc = '{valid: 1'b1, addr: 20'h00000};
    repeat (10) @(posedge clk);
    chk({low_n, mid_n}, 20'h0001F);
    #1 rst_n = 1'b1;
    cyc = '0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    mem(20'h00000);
    reg_op(1'b1, `LOW_REGION_LIMIT_OFS_MID_SIZE, 16'h0100);
    mem(20'h00800);
    reg_op(1'b0, `LOW_REGION_LIMIT_OFS_MID_BASE, 16'h0000);
    mem(20'h00800);
    reg_op(1'b1, 8'hA4, 16'hFFFF);
    reg_op(1'b0, 8'hA4, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      // limit patterns only from the legal size list
      reg_op(1'b1, `LOW_REGION_LIMIT_OFS_LOW_LIMIT, ((16'h0001 << i) - 16'h0001) << 6 | 16'h0038 | 16'(i % 8));
      reg_op(1'b0, `LOW_REGION_LIMIT_OFS_LOW_LIMIT, 16'h0000);
      mem({lim[15:6], 10'h3FF});
      mem({lim[15:6], 10'h3FF} + 20'h00001);
      mem(20'(rnd()) & {lim[15:6], 10'h3FF});
    end
    for (int k = 0; k < 6; k++) mid_run(k, 7'h40 | (7'(rnd()) & (7'h7F << k)), 3'(rnd()));
    // write then read back to back, no idle cycle between
    @(posedge clk) #1;
    req = '{rd: 1'b0, wr: 1'b1, ofs: `LOW_REGION_LIMIT_OFS_MID_BASE, wdata: 16'h1234};
    @(posedge clk) #1;
    req = '{rd: 1'b1, wr: 1'b0, ofs: `LOW_REGION_LIMIT_OFS_MID_BASE, wdata: 16'h0000};
    base = 16'h1234;
    @(posedge clk) #1;
    req = '0;
    chk(rdata, 16'h1234);
    do_reset();
    mid_run(6, 7'h00, 3'h2);
    report_and_stop();
  end
endmodule
